// >>> hdl/sfq_decoder.sv
/*
 Serial flash command front end: link engine, event FIFO, Avalon-MM slave.
 Assumes cs_n, sclk and io_in are synchronous to clock, sclk well below clock/2.
*/
// Contract
// - Opcode 35h switches the device into the four-line protocol.
// - In that protocol command, address and data run 4-4-4 and the quad enable bit is untouched.
// - Opcode F5h is the only way out of the four-line protocol.
// - After F5h command cycles return to one line.
// - In the four-line protocol command, address and output data all use four lines.
// - Opcode 02h with three address bytes and 1-256 data bytes programs the page.
// - Opcode 20h with three address bytes erases the containing sector.
// - Opcode D8h with three address bytes erases the 64 KB block.
// - Fast and multi-line reads take their dummy count from configuration bits 7:6.
// - Program, erase and mode switch execute only if select rises on a byte boundary.
// - Input is sampled on the rising and output shifted on the falling serial clock.
// - While busy, array accesses are ignored and do not disturb the operation.
// - Opcode 06h sets the write latch flag.
`timescale 1ns/1ns
`default_nettype none
module sfq_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_ff [D];
  logic [AW-1:0] wp_ff;
  logic [AW-1:0] rp_ff;
  logic [AW:0] cnt_ff;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = cnt_ff != (AW+1)'(D);
  assign out_valid = cnt_ff != '0;
  assign out_data = mem_ff[rp_ff];
  always_ff @(posedge clock)
  begin
    if (push)
      mem_ff[wp_ff] <= in_data;
  end
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      if (push)
        wp_ff <= (wp_ff == AW'(D - 1)) ? '0 : wp_ff + 1'b1;
      if (pop)
        rp_ff <= (rp_ff == AW'(D - 1)) ? '0 : rp_ff + 1'b1;
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : sfq_fifo

module sfq_decoder #(
  parameter int DEPTH = sfq_pkg::FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  sfq_pkg::sfq_state_e st_ff, nxt_st;
  logic sclk_ff, cs_ff, quad_ff, qen_ff, busy_ff, wlatch_ff, ovf_ff, rej_ff, wait_ff;
  logic [2:0] cnt_ff, ocnt_ff;
  logic [8:0] bcnt_ff;
  logic [7:0] sr_ff, op_ff, cfg_ff, tx_ff, txsr_ff;
  logic [23:0] addr_ff;
  logic [3:0] io_out_ff, io_oe_ff;
  logic [31:0] rdata_ff;

  function automatic logic [2:0] addr_lanes(input logic [7:0] op, input logic q);
    addr_lanes = (q || op == sfq_pkg::OP_QIO) ? 3'd4 : (op == sfq_pkg::OP_DIO) ? 3'd2 : 3'd1;
  endfunction : addr_lanes
  function automatic logic [2:0] out_lanes(input logic [7:0] op, input logic q);
    if (q || op == sfq_pkg::OP_QIO || op == sfq_pkg::OP_QOUT)
      out_lanes = 3'd4;
    else if (op == sfq_pkg::OP_DIO || op == sfq_pkg::OP_DOUT)
      out_lanes = 3'd2;
    else
      out_lanes = 3'd1;
  endfunction : out_lanes
  function automatic logic is_read(input logic [7:0] op);
    is_read = op inside {sfq_pkg::OP_RD, sfq_pkg::OP_FRD, sfq_pkg::OP_DIO,
                         sfq_pkg::OP_DOUT, sfq_pkg::OP_QIO, sfq_pkg::OP_QOUT};
  endfunction : is_read
  function automatic logic is_pgm(input logic [7:0] op);
    is_pgm = op == sfq_pkg::OP_PROG || op == sfq_pkg::OP_QPP;
  endfunction : is_pgm
  function automatic logic is_ers(input logic [7:0] op);
    is_ers = op inside {sfq_pkg::OP_SEC, sfq_pkg::OP_B32, sfq_pkg::OP_B64,
                        sfq_pkg::OP_CE1, sfq_pkg::OP_CE2};
  endfunction : is_ers
  // Opcodes allowed in the current line mode
  function automatic logic op_legal(input logic [7:0] op, input logic q);
    case (op)
      sfq_pkg::OP_RD, sfq_pkg::OP_FRD, sfq_pkg::OP_DIO, sfq_pkg::OP_DOUT,
      sfq_pkg::OP_QOUT, sfq_pkg::OP_QPP, sfq_pkg::OP_QENTRY: op_legal = !q;
      sfq_pkg::OP_QEXIT: op_legal = q;
      sfq_pkg::OP_QIO, sfq_pkg::OP_PROG, sfq_pkg::OP_SEC, sfq_pkg::OP_B32, sfq_pkg::OP_B64,
      sfq_pkg::OP_CE1, sfq_pkg::OP_CE2, sfq_pkg::OP_WR_EN: op_legal = 1'b1;
      default: op_legal = 1'b0;
    endcase
  endfunction : op_legal
  function automatic logic [3:0] out_bits(input logic [7:0] b, input logic [2:0] n);
    out_bits = (n == 3'd4) ? b[7:4] : (n == 3'd2) ? {2'b00, b[7:6]} : {2'b00, b[7], 1'b0};
  endfunction : out_bits

  // Link edges, sampled as ordinary synchronous inputs
  wire sclk_rise = sclk && !sclk_ff;
  wire sclk_fall = !sclk && sclk_ff;
  wire cs_rise = cs_n && !cs_ff;
  wire cs_fall = !cs_n && cs_ff;
  wire [2:0] olanes = quad_ff ? 3'd4 : 3'd1;
  wire [2:0] lanes = (st_ff == sfq_pkg::ST_ADDR) ? addr_lanes(op_ff, quad_ff) :
                     (st_ff == sfq_pkg::ST_DIN && op_ff == sfq_pkg::OP_QPP) ? 3'd4 : olanes;
  wire [2:0] lo = out_lanes(op_ff, quad_ff);
  wire [7:0] sr_nxt = (lanes == 3'd4) ? {sr_ff[3:0], io_in} :
                      (lanes == 3'd2) ? {sr_ff[5:0], io_in[1:0]} : {sr_ff[6:0], io_in[0]};
  wire [3:0] cnt_sum = {1'b0, cnt_ff} + {1'b0, lanes};
  wire byte_done = sclk_rise && !cs_n && cnt_sum[3];
  wire opc_done = byte_done && st_ff == sfq_pkg::ST_OPC;
  wire arr = is_read(sr_nxt) || is_pgm(sr_nxt) || is_ers(sr_nxt);
  wire addr_done = byte_done && st_ff == sfq_pkg::ST_ADDR && bcnt_ff == 9'(sfq_pkg::ADDR_BYTES - 1);
  wire [23:0] addr_full = {addr_ff[15:0], sr_nxt};
  // Dummy count from the two select bits
  wire [1:0] dc_sel = {cfg_ff[sfq_pkg::CFG_DC_HI], cfg_ff[sfq_pkg::CFG_DC_LO]};
  wire [4:0] dummy_n = (dc_sel == 2'd0) ? sfq_pkg::DUMMY_SEL0 : (dc_sel == 2'd1) ? sfq_pkg::DUMMY_SEL1 :
                       (dc_sel == 2'd2) ? sfq_pkg::DUMMY_SEL2 : sfq_pkg::DUMMY_SEL3;
  wire dummy_end = st_ff == sfq_pkg::ST_DUMMY && sclk_rise && bcnt_ff + 9'd1 == {4'h0, dummy_n};
  // Byte boundary check at select rise
  wire boundary = cnt_ff == 3'd0;
  wire ends_cmd = cs_rise && (st_ff == sfq_pkg::ST_WAITCS || st_ff == sfq_pkg::ST_DIN);
  wire exec = ends_cmd && boundary && !(st_ff == sfq_pkg::ST_DIN && bcnt_ff == 9'd0);
  wire reject = ends_cmd && !exec;

  always_comb
  begin
    nxt_st = st_ff;
    if (cs_n)
      nxt_st = sfq_pkg::ST_IDLE;
    else if (cs_fall)
      nxt_st = sfq_pkg::ST_OPC;
    else if (opc_done)
    begin
      if (!op_legal(sr_nxt, quad_ff) || (busy_ff && arr))
        nxt_st = sfq_pkg::ST_IGNORE;
      else if (is_read(sr_nxt) || is_pgm(sr_nxt) ||
               sr_nxt == sfq_pkg::OP_SEC || sr_nxt == sfq_pkg::OP_B32 || sr_nxt == sfq_pkg::OP_B64)
        nxt_st = sfq_pkg::ST_ADDR;
      else
        nxt_st = sfq_pkg::ST_WAITCS;
    end
    else if (addr_done)
    begin
      // Normal read has no dummy phase
      if (op_ff == sfq_pkg::OP_RD)
        nxt_st = sfq_pkg::ST_DOUT;
      else if (is_read(op_ff))
        nxt_st = sfq_pkg::ST_DUMMY;
      else if (is_pgm(op_ff))
        nxt_st = sfq_pkg::ST_DIN;
      else
        nxt_st = sfq_pkg::ST_WAITCS;
    end
    else if (dummy_end)
      nxt_st = sfq_pkg::ST_DOUT;
  end

  // Event stream toward software
  sfq_pkg::sfq_evt_s push_evt;
  sfq_pkg::sfq_evt_s head;
  logic push_ready, head_valid;
  wire ev_read = addr_done && is_read(op_ff);
  wire ev_data = byte_done && st_ff == sfq_pkg::ST_DIN;
  wire ev_end = ends_cmd && (st_ff == sfq_pkg::ST_DIN || (exec && is_ers(op_ff)));
  wire push_valid = ev_read || ev_data || ev_end;
  always_comb
  begin
    push_evt.addr = ev_read ? addr_full : addr_ff;
    push_evt.data = sr_nxt;
    if (ev_read)
      push_evt.kind = sfq_pkg::EV_READ;
    else if (ev_data)
      push_evt.kind = sfq_pkg::EV_PDATA;
    else if (st_ff == sfq_pkg::ST_DIN)
      push_evt.kind = exec ? sfq_pkg::EV_COMMIT : sfq_pkg::EV_ABORT;
    else
      case (op_ff)
        sfq_pkg::OP_SEC: push_evt.kind = sfq_pkg::EV_SEC;
        sfq_pkg::OP_B32: push_evt.kind = sfq_pkg::EV_B32;
        sfq_pkg::OP_B64: push_evt.kind = sfq_pkg::EV_B64;
        default: push_evt.kind = sfq_pkg::EV_CHIP;
      endcase
  end

  // Avalon-MM: one wait state, then accept
  wire acc = (avs_read || avs_write) && !wait_ff;
  wire wr_stat = acc && avs_write && avs_address == sfq_pkg::OFF_STAT;
  wire pop = acc && avs_read && avs_address == sfq_pkg::OFF_EVT;
  wire [7:0] stat = {1'b0, rej_ff, ovf_ff, head_valid, qen_ff, quad_ff, wlatch_ff, busy_ff};
  wire [31:0] rd_mux = (avs_address == sfq_pkg::OFF_CFG) ? {24'h0, cfg_ff} :
                       (avs_address == sfq_pkg::OFF_STAT) ? {24'h0, stat} :
                       (avs_address == sfq_pkg::OFF_EVT) ? {head_valid, 3'h0, head.kind, head.addr} :
                       (avs_address == sfq_pkg::OFF_EDAT) ? {24'h0, head.data} :
                       (avs_address == sfq_pkg::OFF_TX) ? {24'h0, tx_ff} : 32'h0;

  sfq_fifo #(.W($bits(sfq_pkg::sfq_evt_s)), .D(DEPTH)) u_fifo (
    .clock(clock),
    .nrst(nrst),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_evt),
    .out_valid(head_valid),
    .out_ready(pop),
    .out_data(head)
  );

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      sclk_ff <= 1'b0;
      cs_ff <= 1'b1;
      st_ff <= sfq_pkg::ST_IDLE;
      cnt_ff <= 3'd0;
      sr_ff <= 8'h00;
      op_ff <= 8'h00;
    end
    else
    begin
      sclk_ff <= sclk;
      cs_ff <= cs_n;
      st_ff <= nxt_st;
      // Input sampled on rising serial clock
      if (cs_fall || cs_n)
        cnt_ff <= 3'd0;
      else if (sclk_rise)
        cnt_ff <= cnt_sum[2:0];
      if (sclk_rise)
        sr_ff <= sr_nxt;
      if (opc_done)
        op_ff <= sr_nxt;
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      bcnt_ff <= 9'd0;
      addr_ff <= 24'h0;
    end
    else
    begin
      if (opc_done || addr_done)
        bcnt_ff <= 9'd0;
      else if ((byte_done && st_ff == sfq_pkg::ST_ADDR) || (ev_data && bcnt_ff != sfq_pkg::PAGE_BYTES) ||
               (st_ff == sfq_pkg::ST_DUMMY && sclk_rise))
        bcnt_ff <= bcnt_ff + 9'd1;
      if (byte_done && st_ff == sfq_pkg::ST_ADDR)
        addr_ff <= addr_full;
      else if (ev_data)
        addr_ff <= {addr_ff[23:8], addr_ff[7:0] + 8'h01};
    end
  end

  // Output shifted on falling serial clock
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      io_out_ff <= 4'h0;
      io_oe_ff <= 4'h0;
      ocnt_ff <= 3'd0;
      txsr_ff <= 8'h00;
    end
    else if (st_ff != sfq_pkg::ST_DOUT || cs_n)
    begin
      io_oe_ff <= 4'h0;
      ocnt_ff <= 3'd0;
    end
    else if (sclk_fall)
    begin
      io_out_ff <= out_bits(ocnt_ff == 3'd0 ? tx_ff : txsr_ff, lo);
      txsr_ff <= 8'((ocnt_ff == 3'd0 ? tx_ff : txsr_ff) << lo);
      io_oe_ff <= (lo == 3'd4) ? 4'hf : (lo == 3'd2) ? 4'h3 : 4'h2;
      ocnt_ff <= ocnt_ff + lo;
    end
  end

  // Mode, latch and busy flags; hardware set wins over software clear
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      quad_ff <= 1'b0;
      wlatch_ff <= 1'b0;
      busy_ff <= 1'b0;
      ovf_ff <= 1'b0;
      rej_ff <= 1'b0;
    end
    else
    begin
      if (exec && op_ff == sfq_pkg::OP_QENTRY)
        quad_ff <= 1'b1;
      else if (exec && op_ff == sfq_pkg::OP_QEXIT)
        quad_ff <= 1'b0;
      if (exec && op_ff == sfq_pkg::OP_WR_EN)
        wlatch_ff <= 1'b1;
      else if (exec && (is_ers(op_ff) || is_pgm(op_ff)))
        wlatch_ff <= 1'b0;
      if (exec && (is_ers(op_ff) || is_pgm(op_ff)))
        busy_ff <= 1'b1;
      else if (wr_stat && avs_writedata[sfq_pkg::ST_BUSY])
        busy_ff <= 1'b0;
      if (push_valid && !push_ready)
        ovf_ff <= 1'b1;
      else if (wr_stat && avs_writedata[sfq_pkg::ST_OVF])
        ovf_ff <= 1'b0;
      if (reject)
        rej_ff <= 1'b1;
      else if (wr_stat && avs_writedata[sfq_pkg::ST_REJ])
        rej_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      wait_ff <= 1'b1;
      rdata_ff <= 32'h0;
      cfg_ff <= sfq_pkg::CFG_RST;
      tx_ff <= 8'h00;
      qen_ff <= 1'b0;
    end
    else
    begin
      wait_ff <= wait_ff ? !(avs_read || avs_write) : 1'b1;
      if (avs_read && wait_ff)
        rdata_ff <= rd_mux;
      if (acc && avs_write && avs_address == sfq_pkg::OFF_CFG)
        cfg_ff <= avs_writedata[7:0];
      if (acc && avs_write && avs_address == sfq_pkg::OFF_TX)
        tx_ff <= avs_writedata[7:0];
      // Only software moves the quad enable bit
      if (wr_stat)
        qen_ff <= avs_writedata[sfq_pkg::ST_QENB];
    end
  end

  assign io_out = io_out_ff;
  assign io_oe = io_oe_ff;
  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = wait_ff;

  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence s_good_end(logic [7:0] op);
    exec && op_ff == op;
  endsequence
  a_quad_entry: assert property (s_good_end(sfq_pkg::OP_QENTRY) |=> quad_ff) else $error("entry missed");
  a_qen_kept: assert property (quad_ff != $past(quad_ff) |-> $stable(qen_ff)) else $error("enable bit moved");
  a_quad_exit: assert property (s_good_end(sfq_pkg::OP_QEXIT) |=> !quad_ff) else $error("exit missed");
  a_quad_stays: assert property ($fell(quad_ff) |-> $past(op_ff) == sfq_pkg::OP_QEXIT) else $error("left");
  a_erase_push: assert property (s_good_end(sfq_pkg::OP_SEC) |-> push_valid ##1 busy_ff) else $error("erase");
  a_dummy_len: assert property (dummy_end |=> st_ff == sfq_pkg::ST_DOUT) else $error("dummy length");
  a_reject_end: assert property (reject |=> rej_ff && $stable(quad_ff) && $stable(busy_ff)) else $error("rej");
  a_busy_ignore: assert property (opc_done && busy_ff && arr |=> st_ff == sfq_pkg::ST_IGNORE) else $error("busy");
  a_latch_set: assert property (s_good_end(sfq_pkg::OP_WR_EN) |=> wlatch_ff) else $error("latch");
  a_out_fall: assert property (st_ff == sfq_pkg::ST_DOUT && !cs_n && sclk_fall |=> io_oe_ff != 4'h0) else $error("oe");
endmodule : sfq_decoder
`default_nettype wire

// >>> hdl/sfq_pkg.sv
/*
 Shared constants and types for the quad-protocol serial flash command decoder.
 Assumes one 125 MHz clock and a 32-bit Avalon-MM register port.
*/
package sfq_pkg;
  localparam int CLK_MHZ = 125;
  // Opcodes
  localparam logic [7:0] OP_RD = 8'h03;
  localparam logic [7:0] OP_FRD = 8'h0b;
  localparam logic [7:0] OP_DIO = 8'hbb;
  localparam logic [7:0] OP_DOUT = 8'h3b;
  localparam logic [7:0] OP_QIO = 8'heb;
  localparam logic [7:0] OP_QOUT = 8'h6b;
  localparam logic [7:0] OP_PROG = 8'h02;
  localparam logic [7:0] OP_QPP = 8'h38;
  localparam logic [7:0] OP_SEC = 8'h20;
  localparam logic [7:0] OP_B32 = 8'h52;
  localparam logic [7:0] OP_B64 = 8'hd8;
  localparam logic [7:0] OP_CE1 = 8'h60;
  localparam logic [7:0] OP_CE2 = 8'hc7;
  localparam logic [7:0] OP_QENTRY = 8'h35;
  localparam logic [7:0] OP_QEXIT = 8'hf5;
  localparam logic [7:0] OP_WR_EN = 8'h06;
  // Register byte offsets
  localparam logic [4:0] OFF_CFG = 5'h00;
  localparam logic [4:0] OFF_STAT = 5'h04;
  localparam logic [4:0] OFF_EVT = 5'h08;
  localparam logic [4:0] OFF_EDAT = 5'h0c;
  localparam logic [4:0] OFF_TX = 5'h10;
  // Configuration and status fields
  localparam int CFG_DC_LO = 6;
  localparam int CFG_DC_HI = 7;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam int ST_BUSY = 0;
  localparam int ST_WLATCH = 1;
  localparam int ST_QUAD = 2;
  localparam int ST_QENB = 3;
  localparam int ST_EVT = 4;
  localparam int ST_OVF = 5;
  localparam int ST_REJ = 6;
  // Dummy clocks per select code
  localparam logic [4:0] DUMMY_SEL0 = 5'h08;
  localparam logic [4:0] DUMMY_SEL1 = 5'h06;
  localparam logic [4:0] DUMMY_SEL2 = 5'h08;
  localparam logic [4:0] DUMMY_SEL3 = 5'h0a;
  localparam int ADDR_BYTES = 3;
  localparam logic [8:0] PAGE_BYTES = 9'h100;
  localparam int FIFO_DEPTH = 8;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_OPC = 3'b001, ST_ADDR = 3'b010, ST_DUMMY = 3'b011,
    ST_DIN = 3'b100, ST_DOUT = 3'b101, ST_WAITCS = 3'b110, ST_IGNORE = 3'b111
  } sfq_state_e;

  typedef enum logic [3:0] {
    EV_NONE = 4'h0, EV_READ = 4'h1, EV_PDATA = 4'h2, EV_COMMIT = 4'h3,
    EV_ABORT = 4'h4, EV_SEC = 4'h5, EV_B32 = 4'h6, EV_B64 = 4'h7, EV_CHIP = 4'h8
  } sfq_kind_e;

  typedef struct packed {
    sfq_kind_e kind;
    logic [23:0] addr;
    logic [7:0] data;
  } sfq_evt_s;
endpackage : sfq_pkg

// >>> test/sfq_host_model.sv
/*
 Behavioural host controller that drives select, serial clock and IO lines.
 Assumes the bench calls its tasks right after a rising clock edge.
*/
`timescale 1ns/1ns
`default_nettype none
module sfq_host_model #(
  parameter int HALF = 4
) (
  input wire logic clock,
  output logic cs_n,
  output logic sclk,
  output logic [3:0] io_in,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe
);
  logic [3:0] drv;
  logic hd;
  // Released lines show the inverse of the last value
  assign io_in = (io_oe & io_out) | (~io_oe & (hd ? drv : ~drv));
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    drv = 4'h0;
    hd = 1'b1;
  end
  task automatic cyc(input logic [3:0] d, input logic rd, output logic [3:0] q);
    drv <= d;
    hd <= !rd;
    repeat (HALF) @(posedge clock);
    q = io_in;
    sclk <= 1'b1;
    repeat (HALF) @(posedge clock);
    sclk <= 1'b0;
  endtask : cyc
  task automatic xbyte(input int lanes, input logic rd, input logic [7:0] tx, output logic [7:0] rx);
    logic [3:0] q;
    for (int i = 0; i < 8 / lanes; i++)
    begin
      if (lanes == 4) cyc(tx[7 - 4 * i -: 4], rd, q);
      else cyc({3'b000, tx[7 - i]}, rd, q);
      rx = (lanes == 4) ? {rx[3:0], q} : {rx[6:0], q[1]};
    end
  endtask : xbyte
  task automatic dummy(input int n);
    logic [3:0] q;
    for (int i = 0; i < n; i++) cyc(4'h0, 1'b1, q);
  endtask : dummy
  task automatic sel();
    cs_n <= 1'b0;
    repeat (HALF) @(posedge clock);
  endtask : sel
  task automatic desel();
    repeat (HALF) @(posedge clock);
    cs_n <= 1'b1;
    hd <= 1'b1;
    repeat (4 * HALF) @(posedge clock);
  endtask : desel
endmodule : sfq_host_model
`default_nettype wire

// >>> test/test_sfq_decoder.sv
/*
 Self-checking bench for the flash command decoder and its event FIFO.
 Assumes the host model in sfq_host_model.sv and a 125 MHz clock.
*/
`timescale 1ns/1ns
`default_nettype none
module test_sfq_decoder;
  logic clock, nrst, cs_n, sclk, avs_read, avs_write, avs_waitrequest;
  logic [3:0] io_in, io_out, io_oe;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, r, e, d;
  logic [7:0] b;
  int failures, num_checks, cycles;
  sfq_decoder #(.DEPTH(8)) sfq_decoder_i (.clock(clock), .nrst(nrst), .cs_n(cs_n), .sclk(sclk), .io_in(io_in),
    .io_out(io_out), .io_oe(io_oe), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  sfq_host_model sfq_host_model_i (.clock(clock), .cs_n(cs_n), .sclk(sclk), .io_in(io_in), .io_out(io_out),
    .io_oe(io_oe));
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task automatic wrap_up();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      failures++;
      wrap_up();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    do
    begin
      @(posedge clock);
    end
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic cmd(input int lanes, input logic [7:0] op, input int nadr, input logic [23:0] a);
    logic [7:0] x;
    sfq_host_model_i.sel();
    sfq_host_model_i.xbyte(lanes, 1'b0, op, x);
    for (int i = 0; i < nadr; i++) sfq_host_model_i.xbyte(lanes, 1'b0, a[23 - 8 * i -: 8], x);
  endtask : cmd
  task automatic ev();
    bus(1'b0, sfq_pkg::OFF_EDAT, 32'h0, d);
    bus(1'b0, sfq_pkg::OFF_EVT, 32'h0, e);
  endtask : ev
  task automatic t_latch();
    bus(1'b0, sfq_pkg::OFF_STAT, 32'h0, r);
    check(r, 32'h0);
    cmd(1, sfq_pkg::OP_WR_EN, 0, 24'h0);
    sfq_host_model_i.desel();
    bus(1'b0, sfq_pkg::OFF_STAT, 32'h0, r);
    check(r & 32'h2, 32'h2);
  endtask : t_latch
  task automatic t_erase();
    logic [7:0] ops [5];
    logic [3:0] kinds [5];
    ops = '{sfq_pkg::OP_SEC, sfq_pkg::OP_B32, sfq_pkg::OP_B64, sfq_pkg::OP_CE1, sfq_pkg::OP_CE2};
    kinds = '{sfq_pkg::EV_SEC, sfq_pkg::EV_B32, sfq_pkg::EV_B64, sfq_pkg::EV_CHIP, sfq_pkg::EV_CHIP};
    for (int k = 0; k < 5; k++)
    begin
      cmd(1, ops[k], (k < 3) ? 3 : 0, 24'h120000);
      sfq_host_model_i.desel();
      ev();
      check(e & ((k < 3) ? 32'h8fffffff : 32'h8f000000), {4'h8, kinds[k], (k < 3) ? 24'h120000 : 24'h0});
      bus(1'b0, sfq_pkg::OFF_STAT, 32'h0, r);
      check(r & 32'h3, 32'h1);
      cmd(1, sfq_pkg::OP_RD, 3, 24'h000010);
      sfq_host_model_i.desel();
      bus(1'b0, sfq_pkg::OFF_EVT, 32'h0, r);
      check(r & 32'h80000000, 32'h0);
      bus(1'b1, sfq_pkg::OFF_STAT, 32'h1, r);
    end
  endtask : t_erase
  task automatic t_abort();
    logic [3:0] q;
    cmd(1, sfq_pkg::OP_PROG, 3, 24'h000100);
    for (int i = 0; i < 4; i++) sfq_host_model_i.cyc(4'h1, 1'b0, q);
    sfq_host_model_i.desel();
    ev();
    check(e & 32'h8f000000, {4'h8, sfq_pkg::EV_ABORT, 24'h0});
    bus(1'b0, sfq_pkg::OFF_STAT, 32'h0, r);
    check(r & 32'h41, 32'h40);
    bus(1'b1, sfq_pkg::OFF_STAT, 32'h40, r);
    bus(1'b0, sfq_pkg::OFF_STAT, 32'h0, r);
    check(r & 32'h40, 32'h0);
    // Quad-input program: one byte on four lines, then a commit
    cmd(1, sfq_pkg::OP_QPP, 3, 24'h000300);
    sfq_host_model_i.xbyte(4, 1'b0, 8'h5a, b);
    sfq_host_model_i.desel();
    ev();
    check(d & 32'hff, 32'h5a);
    check(e & 32'h8fffffff, {4'h8, sfq_pkg::EV_PDATA, 24'h000300});
    ev();
    check(e & 32'h8f000000, {4'h8, sfq_pkg::EV_COMMIT, 24'h0});
    bus(1'b1, sfq_pkg::OFF_STAT, 32'h1, r);
  endtask : t_abort
  task automatic t_fill();
    cmd(1, sfq_pkg::OP_PROG, 3, 24'h0004fe);
    for (int i = 0; i < 9; i++) sfq_host_model_i.xbyte(1, 1'b0, 8'(i * 16 + 3), b);
    sfq_host_model_i.desel();
    bus(1'b0, sfq_pkg::OFF_STAT, 32'h0, r);
    check(r & 32'h21, 32'h21);
    for (int i = 0; i < 8; i++)
    begin
      ev();
      check(d & 32'hff, 32'(i * 16 + 3));
      check(e & ((i == 0) ? 32'h8fffffff : 32'h8f000000), {4'h8, sfq_pkg::EV_PDATA, (i == 0) ? 24'h0004fe : 24'h0});
    end
    bus(1'b0, sfq_pkg::OFF_EVT, 32'h0, r);
    check(r & 32'h80000000, 32'h0);
    bus(1'b1, sfq_pkg::OFF_STAT, 32'h21, r);
    bus(1'b0, 5'h1c, 32'h0, r);
    check(r, 32'h0);
  endtask : t_fill
  task automatic t_read();
    logic [7:0] op;
    int ln;
    bus(1'b1, sfq_pkg::OFF_TX, 32'h000000a5, r);
    for (int k = 0; k < 3; k++)
    begin
      op = (k == 0) ? sfq_pkg::OP_RD : (k == 1) ? sfq_pkg::OP_FRD : sfq_pkg::OP_QOUT;
      ln = (k == 2) ? 4 : 1;
      cmd(1, op, 3, 24'h00abcd);
      sfq_host_model_i.dummy((k == 0) ? 0 : int'(sfq_pkg::DUMMY_SEL0));
      sfq_host_model_i.xbyte(ln, 1'b1, 8'h00, b);
      check({24'h0, b}, 32'ha5);
      sfq_host_model_i.xbyte(ln, 1'b1, 8'h00, b);
      check({24'h0, b}, 32'ha5);
      sfq_host_model_i.desel();
      ev();
      check(e & 32'h8fffffff, {4'h8, sfq_pkg::EV_READ, 24'h00abcd});
    end
  endtask : t_read
  task automatic t_quad();
    bus(1'b1, sfq_pkg::OFF_STAT, 32'h08, r);
    cmd(1, sfq_pkg::OP_QENTRY, 0, 24'h0);
    sfq_host_model_i.desel();
    bus(1'b0, sfq_pkg::OFF_STAT, 32'h0, r);
    check(r & 32'h0c, 32'h0c);
    for (int c = 1; c < 4; c += 2)
    begin
      bus(1'b1, sfq_pkg::OFF_CFG, 32'(c << 6), r);
      cmd(4, sfq_pkg::OP_QIO, 3, 24'h001000);
      sfq_host_model_i.dummy((c == 1) ? int'(sfq_pkg::DUMMY_SEL1) : int'(sfq_pkg::DUMMY_SEL3));
      sfq_host_model_i.xbyte(4, 1'b1, 8'h00, b);
      sfq_host_model_i.desel();
      check({24'h0, b}, 32'ha5);
    end
    cmd(4, sfq_pkg::OP_QEXIT, 0, 24'h0);
    sfq_host_model_i.desel();
    bus(1'b0, sfq_pkg::OFF_STAT, 32'h0, r);
    check(r & 32'h0c, 32'h08);
    cmd(1, sfq_pkg::OP_RD, 3, 24'h000200);
    sfq_host_model_i.xbyte(1, 1'b1, 8'h00, b);
    sfq_host_model_i.desel();
    check({24'h0, b}, 32'ha5);
  endtask : t_quad
  initial
  begin
    failures = 0;
    num_checks = 0;
    cycles = 0;
    nrst = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    repeat (12) @(posedge clock);
    nrst <= 1'b1;
    t_latch();
    t_erase();
    t_abort();
    t_fill();
    t_read();
    t_quad();
    wrap_up();
  end
endmodule : test_sfq_decoder
`default_nettype wire
